// ### fss_pkg.sv
/*
  Package for the fault safe-state configuration block: register offsets,
  field positions, reset values and field codes.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package fss_pkg;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] FSS_OFS_CFG = 8'h00;   // Safe-state configuration
    localparam logic [7:0] FSS_OFS_RPT = 8'h04;   // Serial fault reporting
    localparam logic [7:0] FSS_OFS_IST = 8'h08;   // Interrupt status, write one to clear
    localparam logic [7:0] FSS_OFS_IMSK = 8'h0C;  // Interrupt mask
    localparam logic [7:0] FSS_OFS_STAT = 8'h10;  // Live fault and output status

    // ==========================================================
    // Configuration field positions
    localparam int FSS_B_UV = 15;      // primary_undervoltage_safe_state
    localparam int FSS_B_OV = 14;      // primary_overvoltage_safe_state
    localparam int FSS_B_PWM = 13;     // pwm_check_safe_state
    localparam int FSS_B_STP = 11;     // shoot_through_safe_state, two bits
    localparam int FSS_B_RSV = 10;     // Reserved bit
    localparam int FSS_B_SPI = 8;      // serial_comm_safe_state, two bits
    localparam int FSS_B_REG = 7;      // regulator_fault_safe_state
    localparam int FSS_B_IDC = 6;      // interdie_comm_safe_state
    localparam int FSS_B_ODD = 5;      // odd_channel_source_enable
    localparam int FSS_B_EVEN = 4;     // even_channel_source_enable
    localparam int FSS_B_CRC = 3;      // config_integrity_safe_state
    localparam int FSS_B_BIAS = 0;     // analog_bias_select, three bits

    // ==========================================================
    // Reset values
    localparam logic [15:0] FSS_CFG_RST = 16'h0200;
    localparam logic [1:0] FSS_RPT_RST = 2'h1;

    // ==========================================================
    // Field codes
    localparam logic [1:0] FSS_TWO_LOW = 2'h0;     // Pull outputs low
    localparam logic [1:0] FSS_TWO_HIGH = 2'h1;    // Pull outputs high
    localparam logic [1:0] FSS_RPT_ALARM = 2'h0;   // Report on alarm pin
    localparam logic [1:0] FSS_RPT_WARN = 2'h1;    // Report on warning pin

    // ==========================================================
    // Interrupt status bits
    localparam int FSS_I_CRC = 0;      // config_integrity_fault_flag
    localparam int FSS_I_SAFE = 1;     // Safe state engaged
    localparam int FSS_I_W = 2;

    // ==========================================================
    // AXI responses
    localparam logic [1:0] FSS_RESP_OK = 2'h0;
    localparam logic [1:0] FSS_RESP_SLVERR = 2'h2;

endpackage

// ### fss_safe_state.sv
/*
  Fault safe-state configuration register with its AXI4-Lite slave, the
  gate output override, current source and bias enables, serial fault
  routing to the fault pins and one level interrupt.
  Assumes fault inputs arrive already masked and synchronous to aclk.
*/
//
// Behaviour
// - Undervoltage: bit 15 clear pulls outputs low
// - Overvoltage: bit 14 clear pulls outputs low
// - PWM check: bit 13 clear pulls outputs low
// - Shoot-through code: low, high, reserved, none
// - Writing reserved bit 10 sets integrity flag
// - Serial fault code: low, high, none; reset two
// - Regulator fault: bit 7 clear pulls low
// - Inter-die fault: bit 6 clear pulls low
// - Bit 5 enables odd-channel current sources
// - Bit 4 enables even-channel current sources
// - Integrity fault: bit 3 clear pulls low
// - Bias select bits mask inputs one, three, five
// - Serial fault report: alarm, warning, none, reserved
`timescale 1ns/10ps

module fss_safe_state
    import fss_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Fault levels, already masked
    input wire logic uv_fault,
    input wire logic ov_fault,
    input wire logic pwm_chk_fault,
    input wire logic stp_fault,
    input wire logic spi_fault,
    input wire logic reg_fault,
    input wire logic idc_fault,
    input wire logic crc_fault,
    // Normal switching path
    input wire logic pwm_in,
    // Gate stage
    output logic gate_source_output,
    output logic gate_sink_output,
    // Analog input sources and bias
    output logic odd_channel_source_en,
    output logic even_channel_source_en,
    output logic [2:0] analog_bias_en,
    // Fault pins and interrupt
    output logic alarm_pin_n,
    output logic warning_pin_n,
    output logic irq
);

    // ==========================================================
    // Elaboration check
    if (ADDR_W < 5 || ADDR_W > 32)
    begin : g_addr_chk
        $error("fss_safe_state: ADDR_W must be 5 to 32");
    end

    // ==========================================================
    // State
    typedef struct packed {
        logic [15:0] cfg;              // fault_output_state_config
        logic [1:0] rpt;               // Serial fault report route
        logic [FSS_I_W-1:0] ist;       // Sticky interrupt status
        logic [FSS_I_W-1:0] imsk;      // Interrupt mask
        logic aw_got;                  // Write address held
        logic w_got;                   // Write data held
        logic [ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic act_prev;                // Safe state engaged last cycle
        logic src;
        logic snk;
        logic odd_en;
        logic even_en;
        logic [2:0] bias;
        logic alarm_n;
        logic warn_n;
        logic irq;
    } fss_state_t;

    fss_state_t st_q;
    fss_state_t st_d;

    // Merge byte lanes of a write into an old value
    function automatic logic [31:0] fss_merge(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Word-aligned address decode
    function automatic logic fss_hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        return (a[ADDR_W-1:2] == (ADDR_W-2)'(ofs >> 2));
    endfunction

    // Combinational working signals
    logic crc_active;                  // Integrity fault present
    logic low_req;                     // Some fault demands low
    logic high_req;                    // Some fault demands high
    logic [1:0] stp_code;
    logic [1:0] spi_code;
    logic [31:0] wmerged;
    logic [31:0] rd_word;
    logic rd_ok;

    // ==========================================================
    // Next-state logic
    always_comb
    begin
        st_d = st_q;
        stp_code = st_q.cfg[FSS_B_STP +: 2];
        spi_code = st_q.cfg[FSS_B_SPI +: 2];
        crc_active = st_q.ist[FSS_I_CRC] | crc_fault;

        // Fault to safe-state demand; code 0x2 of shoot-through is reserved, treated as no action
        low_req = (uv_fault & ~st_q.cfg[FSS_B_UV])
                | (ov_fault & ~st_q.cfg[FSS_B_OV])
                | (pwm_chk_fault & ~st_q.cfg[FSS_B_PWM])
                | (stp_fault & (stp_code == FSS_TWO_LOW))
                | (spi_fault & (spi_code == FSS_TWO_LOW))
                | (reg_fault & ~st_q.cfg[FSS_B_REG])
                | (idc_fault & ~st_q.cfg[FSS_B_IDC])
                | (crc_active & ~st_q.cfg[FSS_B_CRC]);
        high_req = (stp_fault & (stp_code == FSS_TWO_HIGH))
                 | (spi_fault & (spi_code == FSS_TWO_HIGH));

        // Gate drive: low wins over high, since turning off is the safer state
        if (low_req)
        begin
            st_d.src = 1'b0;
            st_d.snk = 1'b1;
        end
        else if (high_req)
        begin
            st_d.src = 1'b1;
            st_d.snk = 1'b0;
        end
        else
        begin
            st_d.src = pwm_in;
            st_d.snk = ~pwm_in;
        end

        // Analog sources and bias
        st_d.odd_en = st_q.cfg[FSS_B_ODD];
        st_d.even_en = st_q.cfg[FSS_B_EVEN];
        st_d.bias = st_q.cfg[FSS_B_BIAS +: 3] & {3{st_q.cfg[FSS_B_ODD]}};

        // Serial fault reporting; reserved route reports nowhere
        st_d.alarm_n = ~(spi_fault & (st_q.rpt == FSS_RPT_ALARM));
        st_d.warn_n = ~(spi_fault & (st_q.rpt == FSS_RPT_WARN));

        // Safe-state engage event
        st_d.act_prev = low_req | high_req;

        // Write channel capture, either order
        if (st_q.awready && s_axi_awvalid)
        begin
            st_d.aw_got = 1'b1;
            st_d.awaddr = s_axi_awaddr;
        end
        if (st_q.wready && s_axi_wvalid)
        begin
            st_d.w_got = 1'b1;
            st_d.wdata = s_axi_wdata;
            st_d.wstrb = s_axi_wstrb;
        end

        // Response retire
        if (st_q.bvalid && s_axi_bready)
        begin
            st_d.bvalid = 1'b0;
        end

        // Perform write once both halves are held
        wmerged = '0;
        if (st_q.aw_got && st_q.w_got && !st_q.bvalid)
        begin
            st_d.aw_got = 1'b0;
            st_d.w_got = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp = FSS_RESP_OK;
            if (fss_hit(st_q.awaddr, FSS_OFS_CFG))
            begin
                wmerged = fss_merge({16'h0000, st_q.cfg}, st_q.wdata, st_q.wstrb);
                st_d.cfg = wmerged[15:0];
                st_d.cfg[FSS_B_RSV] = 1'b0;  // Reserved bit stores zero; its flag is set below
            end
            else if (fss_hit(st_q.awaddr, FSS_OFS_RPT))
            begin
                if (st_q.wstrb[0])
                begin
                    st_d.rpt = st_q.wdata[1:0];
                end
            end
            else if (fss_hit(st_q.awaddr, FSS_OFS_IST))
            begin
                // Clear only what is not being set this cycle: set wins
                if (st_q.wstrb[0])
                begin
                    st_d.ist = st_d.ist & ~(st_q.wdata[FSS_I_W-1:0] & st_q.ist);
                end
            end
            else if (fss_hit(st_q.awaddr, FSS_OFS_IMSK))
            begin
                if (st_q.wstrb[0])
                begin
                    st_d.imsk = st_q.wdata[FSS_I_W-1:0];
                end
            end
            else if (!fss_hit(st_q.awaddr, FSS_OFS_STAT))
            begin
                // Status is read-only: a write there is ignored with OKAY
                st_d.bresp = FSS_RESP_SLVERR;
            end
        end
        // Set events keep priority over the clear above
        if ((low_req | high_req) & ~st_q.act_prev)
        begin
            st_d.ist[FSS_I_SAFE] = 1'b1;
        end
        if (st_q.aw_got && st_q.w_got && !st_q.bvalid && fss_hit(st_q.awaddr, FSS_OFS_CFG)
            && st_q.wstrb[1] && st_q.wdata[FSS_B_RSV])
        begin
            st_d.ist[FSS_I_CRC] = 1'b1;
        end

        // Ready only while there is room for the half
        st_d.awready = ~st_d.aw_got & ~st_d.bvalid;
        st_d.wready = ~st_d.w_got & ~st_d.bvalid;

        // Read decode
        rd_ok = 1'b1;
        if (fss_hit(s_axi_araddr, FSS_OFS_CFG))
        begin
            rd_word = {16'h0000, st_q.cfg};
        end
        else if (fss_hit(s_axi_araddr, FSS_OFS_RPT))
        begin
            rd_word = {30'h0, st_q.rpt};
        end
        else if (fss_hit(s_axi_araddr, FSS_OFS_IST))
        begin
            rd_word = {30'h0, st_q.ist};
        end
        else if (fss_hit(s_axi_araddr, FSS_OFS_IMSK))
        begin
            rd_word = {30'h0, st_q.imsk};
        end
        else if (fss_hit(s_axi_araddr, FSS_OFS_STAT))
        begin
            rd_word = {20'h0, st_q.snk, st_q.src, st_q.act_prev, crc_fault, idc_fault, reg_fault,
                       spi_fault, stp_fault, pwm_chk_fault, ov_fault, uv_fault, st_q.ist[FSS_I_CRC]};
        end
        else
        begin
            rd_word = 32'h0000_0000;
            rd_ok = 1'b0;
        end

        // Read channel: one outstanding read
        if (st_q.rvalid && s_axi_rready)
        begin
            st_d.rvalid = 1'b0;
        end
        if (st_q.arready && s_axi_arvalid)
        begin
            st_d.rvalid = 1'b1;
            st_d.rdata = rd_word;
            st_d.rresp = rd_ok ? FSS_RESP_OK : FSS_RESP_SLVERR;
        end
        st_d.arready = ~st_d.rvalid & ~(st_q.arready & s_axi_arvalid);

        // Level interrupt from unmasked sticky bits
        st_d.irq = |(st_d.ist & st_d.imsk);
    end

    // ==========================================================
    // State register, synchronous reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_q <= '0;
            st_q.cfg <= FSS_CFG_RST;
            st_q.rpt <= FSS_RPT_RST;
            st_q.snk <= 1'b1;              // Gate held off during reset
            st_q.alarm_n <= 1'b1;
            st_q.warn_n <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ==========================================================
    // Outputs straight from the state register
    assign s_axi_awready = st_q.awready;
    assign s_axi_wready = st_q.wready;
    assign s_axi_bvalid = st_q.bvalid;
    assign s_axi_bresp = st_q.bresp;
    assign s_axi_arready = st_q.arready;
    assign s_axi_rvalid = st_q.rvalid;
    assign s_axi_rdata = st_q.rdata;
    assign s_axi_rresp = st_q.rresp;
    assign gate_source_output = st_q.src;
    assign gate_sink_output = st_q.snk;
    assign odd_channel_source_en = st_q.odd_en;
    assign even_channel_source_en = st_q.even_en;
    assign analog_bias_en = st_q.bias;
    assign alarm_pin_n = st_q.alarm_n;
    assign warning_pin_n = st_q.warn_n;
    assign irq = st_q.irq;

endmodule // fss_safe_state

// ### fss_safe_state_monitor.sv
/*
  Checker for the safe-state block, bound to its top module.
  Assumes one aclk domain and a bus master that keeps AXI4-Lite rules.
*/
`timescale 1ns/10ps
module fss_safe_state_monitor
    import fss_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    // Faults and switching input
    input wire logic uv_fault,
    input wire logic ov_fault,
    input wire logic pwm_chk_fault,
    input wire logic stp_fault,
    input wire logic spi_fault,
    input wire logic reg_fault,
    input wire logic idc_fault,
    input wire logic crc_fault,
    input wire logic pwm_in,
    // Outputs watched
    input wire logic gate_source_output,
    input wire logic gate_sink_output,
    input wire logic odd_channel_source_en,
    input wire logic even_channel_source_en,
    input wire logic [2:0] analog_bias_en
);
    // ==========================================================
    // Shadow of the configuration word
    logic [ADDR_W-1:0] addr_q; // Address of the write in flight
    logic [15:0] data_q; // Low half of its data
    logic [1:0] strb_q; // Its low byte strobes
    logic [15:0] cfg_q; // Committed only when the write retires
    logic low_dem; // Some fault asks for the low state
    logic high_dem; // Some fault asks for the high state
    // Committing late keeps the shadow from running ahead of the device
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cfg_q <= 16'h0200;
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
                addr_q <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready)
            begin
                data_q <= s_axi_wdata[15:0];
                strb_q <= s_axi_wstrb[1:0];
            end
            // Reserved bit always stores zero
            if (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h0 && addr_q == ADDR_W'(8'h00))
                cfg_q <= {strb_q[1] ? data_q[15:8] : cfg_q[15:8], strb_q[0] ? data_q[7:0] : cfg_q[7:0]} & 16'hFBFF;
        end
    end
    assign low_dem = (uv_fault && !cfg_q[15]) || (ov_fault && !cfg_q[14]) || (pwm_chk_fault && !cfg_q[13])
        || (stp_fault && cfg_q[12:11] == 2'h0) || (spi_fault && cfg_q[9:8] == 2'h0) || (reg_fault && !cfg_q[7])
        || (idc_fault && !cfg_q[6]) || (crc_fault && !cfg_q[3]);
    assign high_dem = (stp_fault && cfg_q[12:11] == 2'h1) || (spi_fault && cfg_q[9:8] == 2'h1);

    // ==========================================================
    // Assertions; a retiring write is skipped while the shadow settles
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_low_demand:
        assert property (low_dem && !s_axi_bvalid |=> !gate_source_output && gate_sink_output)
        else $error("gate not pulled low on fault");
    a_high_demand:
        assert property (!low_dem && high_dem && cfg_q[3] && !s_axi_bvalid |=> gate_source_output && !gate_sink_output)
        else $error("gate not pulled high on fault");
    a_follow_input:
        assert property (!low_dem && !high_dem && cfg_q[3] && !s_axi_bvalid
            |=> gate_source_output == $past(pwm_in) && gate_sink_output != $past(pwm_in))
        else $error("gate does not follow switching input");
    a_source_enables:
        assert property (!s_axi_bvalid |-> odd_channel_source_en == cfg_q[5] && even_channel_source_en == cfg_q[4]
            && analog_bias_en == (cfg_q[2:0] & {3{cfg_q[5]}}))
        else $error("source or bias enable differs from configuration");
    a_bias_gated:
        assert property (analog_bias_en != 3'h0 |-> odd_channel_source_en)
        else $error("bias on without odd source enable");
    a_gate_exclusive:
        assert property (!(gate_source_output && gate_sink_output))
        else $error("gate source and sink both on");
    a_write_resp:
        assert property (s_wr_taken |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_read_resp:
        assert property (s_rd_taken |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data late");
endmodule // fss_safe_state_monitor

bind fss_safe_state fss_safe_state_monitor #(.ADDR_W(ADDR_W)) u_mon (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .uv_fault, .ov_fault, .pwm_chk_fault, .stp_fault,
    .spi_fault, .reg_fault, .idc_fault, .crc_fault, .pwm_in, .gate_source_output, .gate_sink_output,
    .odd_channel_source_en, .even_channel_source_en, .analog_bias_en);

// ### fss_gate_model.sv
/*
  Behavioural model of the power transistor gate on the split outputs.
  Assumes the gate keeps its charge while neither output drives it.
*/
`timescale 1ns/10ps
module fss_gate_model
(
    // Gate stage
    input wire logic gate_source_output,
    input wire logic gate_sink_output,
    // Gate level seen by the transistor
    output logic gate_level
);
    // ==========================================================
    // Sink wins; with no drive the charge is held
    initial gate_level = 1'b0;
    always @(gate_source_output or gate_sink_output)
    begin
        if (gate_sink_output)
            gate_level = 1'b0;
        else if (gate_source_output)
            gate_level = 1'b1;
    end
endmodule // fss_gate_model

// ### fss_safe_state_test.sv
/*
  Self-checking bench for the safe-state block and its gate model.
  Assumes the checker is bound from its own file.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; $display("unexpected at %0t: %h vs %h", $time, g, e); end end
module fss_safe_state_test
    import fss_pkg::*;
;
    // ==========================================================
    // Signals
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, pwm_in, gate_source_output, gate_sink_output;
    logic odd_channel_source_en, even_channel_source_en, alarm_pin_n, warning_pin_n, irq, gate;
    logic [7:0] s_axi_awaddr, s_axi_araddr, flt; // Faults: uv,ov,pwm,stp,spi,reg,idc,crc
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [2:0] analog_bias_en;
    int errors, n_tests;

    fss_safe_state #(.ADDR_W(8)) uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .uv_fault(flt[0]), .ov_fault(flt[1]), .pwm_chk_fault(flt[2]), .stp_fault(flt[3]), .spi_fault(flt[4]),
        .reg_fault(flt[5]), .idc_fault(flt[6]), .crc_fault(flt[7]), .pwm_in, .gate_source_output,
        .gate_sink_output, .odd_channel_source_en, .even_channel_source_en, .analog_bias_en, .alarm_pin_n,
        .warning_pin_n, .irq);
    fss_gate_model u_gate (.gate_source_output, .gate_sink_output, .gate_level(gate));

    initial
    begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    // ==========================================================
    // Bus tasks; every wait is bounded
    task automatic tally_and_finish();
        if (errors == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge aclk);
    endtask
    // Ready/response lines stay high, so a task may follow another at once
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            n++;
            if (n > 40)
                begin errors++; tally_and_finish(); end
        end while (!s_axi_bvalid);
        `CHK(s_axi_bresp, FSS_RESP_OK)
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            n++;
            if (n > 40)
                begin errors++; tally_and_finish(); end
        end while (!s_axi_rvalid);
        `CHK(s_axi_rresp, er)
        if (er == 2'h0)
            `CHK(s_axi_rdata, ed)
    endtask
    task automatic chk_gate(input logic es);
        `CHK(gate_source_output, es)
        `CHK(gate_sink_output, !es)
        `CHK(gate, es)
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        axi_rd(FSS_OFS_CFG, 32'h00000200, 2'h0);
        axi_rd(FSS_OFS_RPT, 32'h00000001, 2'h0);
        axi_rd(8'h40, 32'h0, 2'h2);
        axi_rd(FSS_OFS_STAT, 32'h00000800, 2'h0);
        `CHK({odd_channel_source_en, even_channel_source_en, analog_bias_en}, 5'h00)
        chk_gate(1'b0);
    endtask
    task automatic t_single();
        int bitpos[6] = '{15, 14, 13, 7, 6, 3};
        int fidx[6] = '{0, 1, 2, 5, 6, 7};
        pwm_in <= 1'b1;
        for (int i = 0; i < 6; i++)
            for (int v = 0; v < 2; v++)
            begin
                axi_wr(FSS_OFS_CFG, 32'(v) << bitpos[i], 4'hF);
                flt <= 8'h01 << fidx[i];
                tick(2);
                chk_gate(v == 1);
                flt <= 8'h00;
                tick(1);
            end
    endtask
    task automatic t_codes();
        for (int f = 3; f < 5; f++)
            for (int c = 0; c < 4; c++)
                for (int p = 0; p < 2; p++)
                begin
                    axi_wr(FSS_OFS_CFG, (32'(c) << ((f == 3) ? 11 : 8)) | 32'h00000008, 4'hF);
                    pwm_in <= p[0];
                    flt <= 8'h01 << f;
                    tick(2);
                    chk_gate((c == 0) ? 1'b0 : (c == 1) ? 1'b1 : p[0]);
                    flt <= 8'h00;
                    tick(1);
                end
    endtask
    task automatic t_integrity();
        pwm_in <= 1'b1;
        axi_wr(FSS_OFS_IST, 32'h00000003, 4'hF);
        axi_wr(FSS_OFS_CFG, 32'h00000400, 4'hF);
        tick(2);
        axi_rd(FSS_OFS_CFG, 32'h00000000, 2'h0);
        axi_rd(FSS_OFS_IST, 32'h00000003, 2'h0);
        chk_gate(1'b0);
        `CHK(irq, 1'b0)
        axi_wr(FSS_OFS_IMSK, 32'h00000001, 4'hF);
        tick(2);
        `CHK(irq, 1'b1)
        axi_wr(FSS_OFS_CFG, 32'h00000008, 4'hF);
        tick(2);
        chk_gate(1'b1);
        axi_wr(FSS_OFS_IST, 32'h00000001, 4'hF);
        axi_wr(FSS_OFS_CFG, 32'h00000000, 4'hF);
        tick(2);
        `CHK(irq, 1'b0)
        chk_gate(1'b1);
    endtask
    task automatic t_route();
        flt <= 8'h10;
        for (int c = 0; c < 4; c++)
        begin
            axi_wr(FSS_OFS_RPT, 32'(c), 4'hF);
            tick(2);
            `CHK({alarm_pin_n, warning_pin_n}, {c != 0, c != 1})
        end
        flt <= 8'h00;
    endtask
    task automatic t_sources();
        for (int k = 0; k < 32; k++)
        begin
            axi_wr(FSS_OFS_CFG, 32'(((k & 24) << 1) | (k & 7)), 4'hF);
            tick(2);
            `CHK(odd_channel_source_en, k[4])
            `CHK(even_channel_source_en, k[3])
            `CHK(analog_bias_en, k[2:0] & {3{k[4]}})
        end
        axi_wr(FSS_OFS_CFG, 32'h0000FFFF, 4'hF);
        axi_wr(FSS_OFS_CFG, 32'h00000000, 4'h1);
        axi_rd(FSS_OFS_CFG, 32'h0000FB00, 2'h0);
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        errors = 0;
        n_tests = 0;
        aresetn = 1'b0;
        pwm_in = 1'b0;
        flt = 8'h00;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
        {s_axi_bready, s_axi_rready} = 2'h3;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        tick(2);
        t_reset();
        t_single();
        t_codes();
        t_integrity();
        t_route();
        t_sources();
        tally_and_finish();
    end
endmodule // fss_safe_state_test
